// ### shared/rmp_pkg.sv
// Shared constants, field layouts and the prescaler code table for the reference monitor block
package rmp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RATE_MULT_LO = 8'h71;
  localparam logic [7:0] OFS_RATE_MULT_HI = 8'h72;
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'h74;
  localparam logic [7:0] OFS_FREQ_LOW_LO = 8'h75;
  localparam logic [7:0] OFS_FREQ_LOW_HI = 8'h76;
  localparam logic [7:0] OFS_FREQ_HIGH_LO = 8'h77;
  localparam logic [7:0] OFS_FREQ_HIGH_HI = 8'h78;
  localparam logic [7:0] OFS_CYCLE_COUNT = 8'h79;
  localparam logic [7:0] OFS_PREDIVIDE = 8'h7A;
  localparam logic [7:0] OFS_PRESCALE = 8'h7B;
  localparam logic [7:0] OFS_MON_STATUS = 8'h7C;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int PREDIV_EN_BIT = 0;
  localparam int REF0_LSB = 0;
  localparam int REF1_LSB = 4;
  localparam int PRESCALE_W = 4;
  localparam int MULT_HI_W = 6;
  localparam int STAT_PERIOD_BIT = 0;
  localparam int STAT_FREQ_BIT = 1;
  localparam logic [1:0] PREDIV_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler codes and edge modulus
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_DIV_1P5 = 4'hA;
  localparam logic [3:0] CODE_DIV_2P5 = 4'hC;
  localparam logic [3:0] CODE_INT_LAST = 4'h7;
  localparam logic [4:0] MOD_DIV_1 = 5'h02;
  localparam logic [4:0] MOD_DIV_1P5 = 5'h03;
  localparam logic [4:0] MOD_DIV_2P5 = 5'h05;

  // Number of input edges (both polarities) per output period
  function automatic logic [4:0] prescale_modulus(input logic [3:0] code);
    logic [4:0] m;
    m = MOD_DIV_1;
    if (code <= CODE_INT_LAST) begin
      m = 5'({code, 1'b0} + 5'h02);
    end else if (code == CODE_DIV_1P5) begin
      m = MOD_DIV_1P5;
    end else if (code == CODE_DIV_2P5) begin
      m = MOD_DIV_2P5;
    end
    return m;
  endfunction : prescale_modulus

endpackage : rmp_pkg

// ### rtl/rmp_edge_detect.sv
// Rising and falling edge pulse detector for a clock-synchronous input
`timescale 1ns/10ps
module rmp_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sampled level and edge pulses
  input wire logic level_in,
  output logic rise_pulse,
  output logic fall_pulse
);

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } rmp_edge_state_type;

  rmp_edge_state_type state_reg;
  rmp_edge_state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.prev = level_in;
    state_next.rise = level_in & ~state_reg.prev;
    state_next.fall = ~level_in & state_reg.prev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rise_pulse = state_reg.rise;
  assign fall_pulse = state_reg.fall;

endmodule : rmp_edge_detect

// ### rtl/rmp_prescaler.sv
// One reference prescaler: integer 1..8 or fractional 1.5 / 2.5 division
`timescale 1ns/10ps
module rmp_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Ratio code and reference
  input wire logic [3:0] ratio_code,
  input wire logic ref_in,
  // Divided reference
  output logic ref_out
);

  typedef struct packed {
    logic prev;
    logic [4:0] edge_cnt;
    logic out;
  } rmp_pre_state_type;

  rmp_pre_state_type state_reg;
  rmp_pre_state_type state_next;
  logic [4:0] modulus;

  always_comb begin
    state_next = state_reg;
    // Counting both edges lets 1.5 and 2.5 come out as 3 and 5 half periods
    modulus = rmp_pkg::prescale_modulus(ratio_code);
    state_next.prev = ref_in;
    if (ref_in != state_reg.prev) begin
      // A shrinking ratio may leave the count past the end; wrap at once
      if (state_reg.edge_cnt >= 5'(modulus - 5'h01)) begin
        state_next.edge_cnt = 5'h00;
      end else begin
        state_next.edge_cnt = 5'(state_reg.edge_cnt + 5'h01);
      end
      state_next.out = (state_next.edge_cnt < {1'b0, modulus[4:1]});
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ref_out = state_reg.out;

endmodule : rmp_prescaler

// ### rtl/rmp_ref_monitor.sv
// Custom B reference monitor configuration, period and frequency checks, and prescalers
`timescale 1ns/10ps
module rmp_ref_monitor #(
  // Counter widths in clk cycles
  parameter int PERIOD_CNT_W = 9,
  parameter int FREQ_CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte register port from the serial control interface
  // A read and a write in the same cycle return the old value
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Reference pins
  input wire logic mon_ref_in,
  input wire logic ref0_in,
  input wire logic ref1_in,
  // Divided references
  output logic ref0_scaled,
  output logic ref1_scaled,
  // Monitor results and configured rate
  output logic period_fail,
  output logic freq_fail,
  output logic [15:0] freq_count,
  output logic [13:0] custom_b_rate_multiplier
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Configuration registers
    logic [7:0] mult_lo;
    logic [5:0] mult_hi;
    logic [7:0] period_high;
    logic [7:0] low_lo;
    logic [7:0] low_hi;
    logic [7:0] high_lo;
    logic [7:0] high_hi;
    logic [7:0] cycle;
    logic predivide;
    logic [7:0] prescale;
    // Read port
    logic [7:0] rdata;
    logic rvalid;
    // Period check
    logic [PERIOD_CNT_W-1:0] per_cnt;
    logic per_seen;
    logic period_fail;
    // Frequency window
    logic [1:0] pre_cnt;
    logic win_run;
    logic [7:0] ev_cnt;
    logic [FREQ_CNT_W-1:0] clk_cnt;
    logic [15:0] freq_count;
    logic freq_fail;
  } rmp_mon_state_type;

  rmp_mon_state_type state_reg;
  rmp_mon_state_type state_next;

  logic mon_rise;
  logic mon_event;
  logic [15:0] low_bound;
  logic [15:0] high_bound;
  logic [PERIOD_CNT_W-1:0] per_limit;
  logic [FREQ_CNT_W-1:0] cnt_step;
  logic [15:0] win_total;
  logic win_below;
  logic win_above;

  // ----------------------------------------------------------------
  // Reference edge detection
  // ----------------------------------------------------------------
  rmp_edge_detect u_mon_edge (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(mon_ref_in),
    .rise_pulse(mon_rise),
    .fall_pulse()
  );

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  rmp_prescaler u_ref0_prescale (
    .clk(clk),
    .sys_rst(sys_rst),
    .ratio_code(state_reg.prescale[rmp_pkg::REF0_LSB +: rmp_pkg::PRESCALE_W]),
    .ref_in(ref0_in),
    .ref_out(ref0_scaled)
  );

  rmp_prescaler u_ref1_prescale (
    .clk(clk),
    .sys_rst(sys_rst),
    .ratio_code(state_reg.prescale[rmp_pkg::REF1_LSB +: rmp_pkg::PRESCALE_W]),
    .ref_in(ref1_in),
    .ref_out(ref1_scaled)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    low_bound = {state_reg.low_hi, state_reg.low_lo};
    high_bound = {state_reg.high_hi, state_reg.high_lo};
    per_limit = PERIOD_CNT_W'(state_reg.period_high);
    cnt_step = FREQ_CNT_W'(1);
    mon_event = 1'b0;
    // Count of a window that closes on this edge, and its bound checks
    win_total = 16'(state_reg.clk_cnt + cnt_step);
    win_below = (win_total < low_bound);
    win_above = (win_total > high_bound);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (reg_wr) begin
      case (reg_addr)
        rmp_pkg::OFS_RATE_MULT_LO: begin
          state_next.mult_lo = reg_wdata;
        end
        rmp_pkg::OFS_RATE_MULT_HI: begin
          state_next.mult_hi = reg_wdata[rmp_pkg::MULT_HI_W-1:0];
        end
        rmp_pkg::OFS_PERIOD_HIGH: begin
          state_next.period_high = reg_wdata;
        end
        rmp_pkg::OFS_FREQ_LOW_LO: begin
          state_next.low_lo = reg_wdata;
        end
        rmp_pkg::OFS_FREQ_LOW_HI: begin
          state_next.low_hi = reg_wdata;
        end
        rmp_pkg::OFS_FREQ_HIGH_LO: begin
          state_next.high_lo = reg_wdata;
        end
        rmp_pkg::OFS_FREQ_HIGH_HI: begin
          state_next.high_hi = reg_wdata;
        end
        rmp_pkg::OFS_CYCLE_COUNT: begin
          state_next.cycle = reg_wdata;
        end
        rmp_pkg::OFS_PREDIVIDE: begin
          state_next.predivide = reg_wdata[rmp_pkg::PREDIV_EN_BIT];
        end
        rmp_pkg::OFS_PRESCALE: begin
          state_next.prescale = reg_wdata;
        end
        default: begin
          // Unmapped offsets and the read-only status byte ignore writes
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads, answered one cycle later; reserved bits read zero
    // ----------------------------------------------------------------
    state_next.rvalid = reg_rd;
    state_next.rdata = rmp_pkg::RST_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        rmp_pkg::OFS_RATE_MULT_LO: begin
          state_next.rdata = state_reg.mult_lo;
        end
        rmp_pkg::OFS_RATE_MULT_HI: begin
          state_next.rdata = {2'h0, state_reg.mult_hi};
        end
        rmp_pkg::OFS_PERIOD_HIGH: begin
          state_next.rdata = state_reg.period_high;
        end
        rmp_pkg::OFS_FREQ_LOW_LO: begin
          state_next.rdata = state_reg.low_lo;
        end
        rmp_pkg::OFS_FREQ_LOW_HI: begin
          state_next.rdata = state_reg.low_hi;
        end
        rmp_pkg::OFS_FREQ_HIGH_LO: begin
          state_next.rdata = state_reg.high_lo;
        end
        rmp_pkg::OFS_FREQ_HIGH_HI: begin
          state_next.rdata = state_reg.high_hi;
        end
        rmp_pkg::OFS_CYCLE_COUNT: begin
          state_next.rdata = state_reg.cycle;
        end
        rmp_pkg::OFS_PREDIVIDE: begin
          state_next.rdata = {7'h00, state_reg.predivide};
        end
        rmp_pkg::OFS_PRESCALE: begin
          state_next.rdata = state_reg.prescale;
        end
        rmp_pkg::OFS_MON_STATUS: begin
          state_next.rdata[rmp_pkg::STAT_PERIOD_BIT] = state_reg.period_fail;
          state_next.rdata[rmp_pkg::STAT_FREQ_BIT] = state_reg.freq_fail;
        end
        default: begin
          state_next.rdata = rmp_pkg::RST_BYTE;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Single-cycle period check on the undivided reference, in clk cycles
    // ----------------------------------------------------------------
    if (mon_rise) begin
      // The first rise after reset only arms the check
      if (state_reg.per_seen) begin
        state_next.period_fail = (state_reg.per_cnt > per_limit);
      end
      state_next.per_seen = 1'b1;
      state_next.per_cnt = '0;
    end else begin
      // Saturating, so a dead reference cannot wrap back into range
      if (state_reg.per_cnt != '1) begin
        state_next.per_cnt = PERIOD_CNT_W'(state_reg.per_cnt + 1'b1);
      end
      // A stopped reference must fail without waiting for an edge
      if (state_reg.per_seen && (state_reg.per_cnt > per_limit)) begin
        state_next.period_fail = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Optional divide-by-four ahead of the frequency count
    // ----------------------------------------------------------------
    if (mon_rise) begin
      if (state_reg.predivide) begin
        state_next.pre_cnt = 2'(state_reg.pre_cnt + 2'h1);
        mon_event = (state_reg.pre_cnt == rmp_pkg::PREDIV_LAST);
      end else begin
        state_next.pre_cnt = 2'h0;
        mon_event = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Frequency count: clk cycles spanned by cycle+1 reference events
    // ----------------------------------------------------------------
    if (state_reg.clk_cnt != '1) begin
      state_next.clk_cnt = FREQ_CNT_W'(state_reg.clk_cnt + cnt_step);
    end
    if (mon_event) begin
      if (!state_reg.win_run) begin
        state_next.win_run = 1'b1;
        state_next.ev_cnt = rmp_pkg::RST_BYTE;
        state_next.clk_cnt = '0;
      end else if (state_reg.ev_cnt >= state_reg.cycle) begin
        // Closing event opens the next window, so no reference cycle is skipped;
        // a cycle value lowered mid-window closes here instead of wrapping past 255
        state_next.freq_count = win_total;
        state_next.freq_fail = win_below || win_above;
        state_next.ev_cnt = rmp_pkg::RST_BYTE;
        state_next.clk_cnt = '0;
      end else begin
        state_next.ev_cnt = 8'(state_reg.ev_cnt + 8'h01);
      end
    end else if (state_reg.win_run && (16'(state_reg.clk_cnt) > high_bound)) begin
      // Too slow is already certain before the window closes
      state_next.freq_fail = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign reg_rvalid = state_reg.rvalid;
  assign period_fail = state_reg.period_fail;
  assign freq_fail = state_reg.freq_fail;
  assign freq_count = state_reg.freq_count;
  assign custom_b_rate_multiplier = {state_reg.mult_hi, state_reg.mult_lo};

endmodule : rmp_ref_monitor

// ### dv/rmp_ref_monitor_props.sv
// Port-level assertions for the reference monitor register bank
`timescale 1ns/10ps
module rmp_ref_monitor_props #(
  parameter int PERIOD_CNT_W = 9,
  parameter int FREQ_CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // References
  input wire logic mon_ref_in,
  input wire logic ref0_in,
  input wire logic ref1_in,
  input wire logic ref0_scaled,
  input wire logic ref1_scaled,
  // Results
  input wire logic period_fail,
  input wire logic freq_fail,
  input wire logic [15:0] freq_count,
  input wire logic [13:0] custom_b_rate_multiplier
);
  logic clean_reg;
  logic [1:0] age_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Divide-by-one gives the inverted input one clk late, while no other ratio was ever loaded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clean_reg <= 1'b1;
      age_reg <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h7B && reg_wdata[3:0] != 4'h0) begin
        clean_reg <= 1'b0;
      end
      if (age_reg != 2'h3) begin
        age_reg <= age_reg + 2'h1;
      end
    end
  end

  chk_rvalid_follows_rd: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  chk_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  chk_rdata_idle_zero: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
    else $error("read data not zero when idle");
  chk_mult_low_byte: assert property (reg_wr && reg_addr == 8'h71 |=>
    custom_b_rate_multiplier[7:0] == $past(reg_wdata)) else $error("multiplier low byte");
  chk_mult_high_bits: assert property (reg_wr && reg_addr == 8'h72 |=>
    {2'h0, custom_b_rate_multiplier[13:8]} == ($past(reg_wdata) & 8'h3F))
    else $error("multiplier high bits");
  chk_predivide_rsvd: assert property (reg_rd && reg_addr == 8'h7A |=>
    reg_rdata[7:1] == 7'h00) else $error("predivide reserved bits set");
  chk_status_read: assert property (reg_rd && reg_addr == 8'h7C |=>
    reg_rdata == {6'h00, $past(freq_fail), $past(period_fail)}) else $error("status read");
  chk_ref0_follow: assert property (clean_reg && age_reg == 2'h3 |->
    ref0_scaled == !$past(ref0_in)) else $error("divide by one not an inverted delay");
endmodule : rmp_ref_monitor_props

bind rmp_ref_monitor rmp_ref_monitor_props #(.PERIOD_CNT_W(PERIOD_CNT_W),
  .FREQ_CNT_W(FREQ_CNT_W)) i_rmp_ref_monitor_props (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .mon_ref_in, .ref0_in,
  .ref1_in, .ref0_scaled, .ref1_scaled, .period_fail, .freq_fail, .freq_count,
  .custom_b_rate_multiplier);

// ### dv/rmp_ref_source.sv
// Free-running reference clock source driving one reference pin
`timescale 1ns/10ps
module rmp_ref_source (
  // Clock
  input wire logic clk,
  // Half period in clk cycles, zero parks the pin
  input wire logic [7:0] half_period,
  // Reference pin
  output logic ref_out
);
  logic [7:0] cnt = 8'h00;

  initial ref_out = 1'b0;

  // Pin moves just after the edge so the block samples a settled level
  always @(posedge clk) begin
    #1;
    if (half_period == 8'h00) begin
      cnt = 8'h00;
    end else if (cnt + 8'h01 >= half_period) begin
      cnt = 8'h00;
      ref_out = ~ref_out;
    end else begin
      cnt = cnt + 8'h01;
    end
  end
endmodule : rmp_ref_source

// ### dv/rmp_ref_monitor_tb_top.sv
// Self-checking bench for the reference monitor register bank
`timescale 1ns/10ps
module rmp_ref_monitor_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid, mon_ref_in, ref0_in, ref1_in, ref0_scaled, ref1_scaled;
  logic period_fail, freq_fail;
  logic [15:0] freq_count;
  logic [13:0] mult;
  logic [7:0] half_mon = 8'h00;
  logic [7:0] half0 = 8'h02;
  logic [7:0] half1 = 8'h03;
  logic [15:0] seed = 16'h002B;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  rmp_ref_monitor i_rmp_ref_monitor (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .reg_rvalid, .mon_ref_in, .ref0_in, .ref1_in, .ref0_scaled,
    .ref1_scaled, .period_fail, .freq_fail, .freq_count, .custom_b_rate_multiplier(mult));
  rmp_ref_source i_rmp_ref_source_mon (.clk, .half_period(half_mon), .ref_out(mon_ref_in));
  rmp_ref_source i_rmp_ref_source_0 (.clk, .half_period(half0), .ref_out(ref0_in));
  rmp_ref_source i_rmp_ref_source_1 (.clk, .half_period(half1), .ref_out(ref1_in));

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Whole run needs about 13000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : rnd

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h72: return 8'h3F;
      8'h7A: return 8'h01;
      8'h70, 8'h73: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : mask

  // Input edges per output period
  function automatic logic [15:0] edges(input logic [3:0] c);
    if (c == 4'hA) return 16'h0003;
    if (c == 4'hC) return 16'h0005;
    return {11'h000, c, 1'b0} + 16'h0002;
  endfunction : edges

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    @(posedge clk) #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    check({15'h0000, reg_rvalid}, 16'h0001);
    d = reg_rdata;
    @(posedge clk) #1;
  endtask : rd

  // Clk cycles between two rising edges of a scaled reference
  task automatic measure(input logic sel, output logic [15:0] n);
    int k;
    int rises;
    logic s;
    logic p;
    k = 0;
    rises = 0;
    p = 1'b1;
    n = 16'h0000;
    while (rises < 2 && k < 200) begin
      @(posedge clk) #1;
      s = sel ? ref1_scaled : ref0_scaled;
      rises += (s && !p) ? 1 : 0;
      n += (rises == 1) ? 16'h0001 : 16'h0000;
      p = s;
      k++;
    end
  endtask : measure

  initial begin
    logic [7:0] d, h, cy, pb;
    logic [7:0] img [12];
    logic [3:0] codes [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hC};
    logic [15:0] lo, hi, cnt, n;
    logic dv, ef, ep;
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int a = 0; a < 12; a++) begin
      rd(8'h70 + 8'(a), d);
      check({8'h00, d}, 16'h0000);
    end
    for (int a = 0; a < 12; a++) begin
      img[a] = (a == 11) ? (rnd() & 8'h77) : rnd();
      wr(8'h70 + 8'(a), img[a]);
    end
    for (int a = 0; a < 12; a++) begin
      rd(8'h70 + 8'(a), d);
      check({8'h00, d}, {8'h00, img[a] & mask(8'h70 + 8'(a))});
    end
    check({2'h0, mult}, {2'h0, img[2][5:0], img[1]});
    for (int i = 0; i < 10; i++) begin
      wr(8'h7B, {codes[9 - i], codes[i]});
      repeat (100) @(posedge clk);
      measure(1'b0, n);
      check(n, edges(codes[i]) * 16'h0002);
      measure(1'b1, n);
      check(n, edges(codes[9 - i]) * 16'h0003);
    end
    for (int t = 0; t < 8; t++) begin
      h = 8'h04 + (rnd() & 8'h07);
      cy = rnd() & 8'h03;
      dv = rnd() > 8'h7F;
      cnt = 16'(int'(h) * 2 * (int'(cy) + 1) * (dv ? 4 : 1));
      lo = cnt + 16'h0001 - {8'h00, rnd() & 8'h03};
      hi = cnt - 16'h0001 + {8'h00, rnd() & 8'h03};
      ep = rnd() > 8'h7F;
      pb = ep ? (h * 8'h02 - 8'h04) : (h * 8'h02 + 8'h02);
      ef = cnt < lo || cnt > hi;
      wr(8'h74, pb);
      wr(8'h75, lo[7:0]);
      wr(8'h76, lo[15:8]);
      wr(8'h77, hi[7:0]);
      wr(8'h78, hi[15:8]);
      wr(8'h79, cy);
      wr(8'h7A, {7'h00, dv});
      half_mon = h;
      repeat (1400) @(posedge clk);
      #1;
      check(freq_count, cnt);
      check({14'h0000, freq_fail, period_fail}, {14'h0000, ef, ep});
      rd(8'h7C, d);
      check({8'h00, d}, {14'h0000, ef, ep});
    end
    print_verdict();
  end
endmodule : rmp_ref_monitor_tb_top
